// File: char_display_host_interface.sv
// Host-side interface of the character display controller with its display and glyph RAM.
//
// The APB interface to the registers and the placing of the registers were left to the implementer.
`include "char_display_cfg.svh"

module char_display_host_interface
   import char_display_pkg::*;
#(
   parameter int unsigned BUSY_CYCLES = `BUSY_TIME_NS * `CLK_MHZ / 1000,
   parameter logic [4:0]  IIC_ADDR_HI = `RST_IIC_HI
) (
   // Clock and reset.
   input  wire logic        mclk_i,
   input  wire logic        sys_rst_i,
   // Host pins.
   input  wire logic        interface_strap_hi_i,
   input  wire logic        interface_strap_lo_i,
   input  wire logic        enable_strobe_i,
   input  wire logic        register_select_i,
   input  wire logic        read_not_write_i,
   input  wire logic [7:0]  host_data_lines_i,
   output logic      [7:0]  host_data_lines_o,
   output logic      [7:0]  host_data_lines_oe_o,
   // APB slave.
   input  wire logic        psel_i,
   input  wire logic        penable_i,
   input  wire logic        pwrite_i,
   input  wire logic [7:0]  paddr_i,
   input  wire logic [31:0] pwdata_i,
   output logic      [31:0] prdata_o,
   output logic             pready_o,
   output logic             pslverr_o
);

   if (BUSY_CYCLES == 0 || BUSY_CYCLES > 65535) begin : g_chk
      $error("BUSY_CYCLES must lie in 1..65535");
   end

   localparam logic [6:0] DISP_LAST = 7'(`DISP_DEPTH - 1);

   ////////////////////////////////////////////////////////////////////////////////
   // Pin synchronisers. Data travels with the strobe so both see the same delay.

   logic [12:0] pin_s1_r;
   logic [12:0] pin_s2_r;
   logic [7:0]  d_prev_r;
   logic        e_prev_r;
   wire  [12:0] pin_raw = {interface_strap_hi_i, interface_strap_lo_i, enable_strobe_i,
                           register_select_i, read_not_write_i, host_data_lines_i};

   always_ff @(posedge mclk_i) begin
      if (sys_rst_i) begin
         pin_s1_r <= 13'h0000;
         pin_s2_r <= 13'h0000;
         d_prev_r <= 8'h00;
         e_prev_r <= 1'b0;
      end else begin
         pin_s1_r <= pin_raw;
         pin_s2_r <= pin_s1_r;
         d_prev_r <= pin_s2_r[7:0];
         e_prev_r <= pin_s2_r[10];
      end
   end

   wire       strap_hi_s = pin_s2_r[12];
   wire       strap_lo_s = pin_s2_r[11];
   wire       e_s        = pin_s2_r[10];
   wire       rs_s       = pin_s2_r[9];
   wire       rw_s       = pin_s2_r[8];
   wire [7:0] d_s        = pin_s2_r[7:0];

   wire link_mode_e mode = strap_lo_s ? MODE_IIC : (strap_hi_s ? MODE_SPI : MODE_PAR);

   ////////////////////////////////////////////////////////////////////////////////
   // Parallel bus. Accesses complete on the falling edge of the enable strobe.

   logic       bus_width_r;
   logic       nib_wait_lo_r;
   logic [3:0] nib_hi_r;

   wire       par_strobe  = (mode == MODE_PAR) & e_prev_r & ~e_s;
   wire       par_done    = par_strobe & (bus_width_r | nib_wait_lo_r);
   wire [7:0] par_byte    = bus_width_r ? d_s : {nib_hi_r, d_s[7:4]};
   wire       par_wr      = par_done & ~rw_s;
   wire       par_rd_data = par_done & rw_s & rs_s;

   always_ff @(posedge mclk_i) begin
      if (sys_rst_i || bus_width_r) begin
         nib_wait_lo_r <= 1'b0;
         nib_hi_r      <= 4'h0;
      end else if (par_strobe) begin
         nib_wait_lo_r <= ~nib_wait_lo_r;
         nib_hi_r      <= d_s[7:4];
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Three-line serial: a select bit first, then eight data bits, most significant first.

   logic [3:0] spi_cnt_r;
   logic [7:0] spi_sh_r;

   wire spi_sel  = (mode == MODE_SPI) & ~d_s[5];
   wire spi_rise = d_s[6] & ~d_prev_r[6];
   wire spi_done = spi_sel & spi_rise & (spi_cnt_r == 4'h8);

   always_ff @(posedge mclk_i) begin
      if (sys_rst_i || !spi_sel) begin
         spi_cnt_r <= 4'h0;
         spi_sh_r  <= 8'h00;
      end else if (spi_rise) begin
         spi_cnt_r <= (spi_cnt_r == 4'h8) ? 4'h0 : spi_cnt_r + 4'h1;
         spi_sh_r  <= {spi_sh_r[6:0], d_s[7]};
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // IIC write-only target. Bytes after the address alternate: control, then data.

   logic [3:0] iic_cnt_r;
   logic [7:0] iic_sh_r;
   logic       iic_rs_r;
   logic       ack_r;
   iic_phase_e iic_ph_r;

   wire       iic_sel   = (mode == MODE_IIC) & ~d_s[5];
   wire       sda       = d_s[6];
   wire       scl       = d_s[7];
   wire       scl_rise  = scl & ~d_prev_r[7];
   wire       scl_fall  = ~scl & d_prev_r[7];
   wire       iic_start = scl & d_prev_r[7] & d_prev_r[6] & ~sda;
   wire       iic_stop  = scl & d_prev_r[7] & ~d_prev_r[6] & sda;
   wire [7:0] iic_addr  = {IIC_ADDR_HI, d_s[1], d_s[0], 1'b0};
   wire       byte_end  = iic_sel & scl_fall & (iic_cnt_r == 4'h8);
   wire       iic_done  = byte_end & (iic_ph_r == PH_DATA);

   always_ff @(posedge mclk_i) begin
      if (sys_rst_i || !iic_sel || iic_stop) begin
         iic_ph_r  <= PH_SKIP;
         iic_cnt_r <= 4'h0;
         ack_r     <= 1'b0;
      end else if (iic_start) begin
         iic_ph_r  <= PH_ADDR;
         iic_cnt_r <= 4'h0;
         ack_r     <= 1'b0;
      end else if (scl_rise && iic_ph_r != PH_SKIP) begin
         iic_cnt_r <= (iic_cnt_r == 4'h8) ? 4'h0 : iic_cnt_r + 4'h1;
         if (iic_cnt_r != 4'h8) begin
            iic_sh_r <= {iic_sh_r[6:0], sda};
         end
      end else if (byte_end) begin
         case (iic_ph_r)
            PH_ADDR: begin
               ack_r    <= (iic_sh_r == iic_addr);
               iic_ph_r <= (iic_sh_r == iic_addr) ? PH_CTRL : PH_SKIP;
            end
            PH_CTRL: begin
               ack_r    <= 1'b1;
               iic_rs_r <= iic_sh_r[6];
               iic_ph_r <= PH_DATA;
            end
            PH_DATA: begin
               ack_r    <= 1'b1;
               iic_ph_r <= PH_CTRL;
            end
            default: begin
               ack_r <= 1'b0;
            end
         endcase
      end else if (scl_fall && iic_cnt_r == 4'h0) begin
         ack_r <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Merge the three links into one write request.

   wire       issue_vld  = par_wr | spi_done | iic_done;
   wire       issue_rs   = par_wr ? rs_s : (spi_done ? spi_sh_r[7] : iic_rs_r);
   wire [7:0] issue_byte = par_wr ? par_byte : (spi_done ? {spi_sh_r[6:0], d_s[7]} : iic_sh_r);

   ////////////////////////////////////////////////////////////////////////////////
   // Command register, busy timing and instruction decode.

   logic [7:0]  cmd_r;
   logic [15:0] busy_cnt_r;
   logic [15:0] busy_time_r;
   logic        inc_r;
   logic        glyph_sel_r;
   logic [6:0]  ptr_r;
   logic [7:0]  dr_r;
   ram_fsm_e    fsm_r;

   wire busy       = (busy_cnt_r != 16'h0000);
   wire fsm_idle   = (fsm_r == ST_IDLE);
   wire cmd_accept = issue_vld & ~issue_rs & ~busy & fsm_idle;
   wire data_wr    = issue_vld & issue_rs & fsm_idle;
   wire data_rd    = par_rd_data & fsm_idle;
   wire set_disp   = cmd_accept & issue_byte[7];
   wire set_glyph  = cmd_accept & (issue_byte[7:6] == 2'b01);

   always_ff @(posedge mclk_i) begin
      if (sys_rst_i) begin
         cmd_r       <= 8'h00;
         busy_cnt_r  <= 16'h0000;
         bus_width_r <= `RST_BUS_WIDTH;
         inc_r       <= `RST_INC;
      end else if (cmd_accept) begin
         cmd_r      <= issue_byte;
         busy_cnt_r <= busy_time_r;
         if (issue_byte[7:5] == 3'b001) begin
            bus_width_r <= issue_byte[`CMD_BIT_WIDTH];
         end
         if (issue_byte[7:2] == 6'b000001) begin
            inc_r <= issue_byte[`CMD_BIT_INC];
         end
      end else if (busy) begin
         busy_cnt_r <= busy_cnt_r - 16'h0001;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Display and glyph RAM behind the data holding register.

   logic [7:0] display_ram [`DISP_DEPTH];
   logic [7:0] glyph_ram   [`GLYPH_DEPTH];

   wire       disp_ok   = (ptr_r <= DISP_LAST);
   wire [6:0] disp_idx  = disp_ok ? ptr_r : 7'h00;
   wire [7:0] ram_rd    = glyph_sel_r ? glyph_ram[ptr_r[5:0]] : display_ram[disp_idx];
   wire [5:0] glyph_nxt = inc_r ? ptr_r[5:0] + 6'h01 : ptr_r[5:0] - 6'h01;
   wire [6:0] disp_nxt  = inc_r ? ((ptr_r == DISP_LAST) ? 7'h00 : ptr_r + 7'h01)
                                : ((ptr_r == 7'h00) ? DISP_LAST : ptr_r - 7'h01);
   wire [6:0] ptr_step  = glyph_sel_r ? {1'b0, glyph_nxt} : disp_nxt;

   always_ff @(posedge mclk_i) begin
      if (sys_rst_i) begin
         ptr_r       <= 7'h00;
         glyph_sel_r <= 1'b0;
         dr_r        <= 8'h00;
         fsm_r       <= ST_IDLE;
      end else begin
         case (fsm_r)
            ST_IDLE: begin
               if (set_disp) begin
                  ptr_r       <= issue_byte[6:0];
                  glyph_sel_r <= 1'b0;
                  fsm_r       <= ST_FETCH;
               end else if (set_glyph) begin
                  ptr_r       <= {1'b0, issue_byte[5:0]};
                  glyph_sel_r <= 1'b1;
                  fsm_r       <= ST_FETCH;
               end else if (data_wr) begin
                  dr_r  <= issue_byte;
                  fsm_r <= ST_STORE;
               end else if (data_rd) begin
                  ptr_r <= ptr_step;
                  fsm_r <= ST_FETCH;
               end
            end
            ST_STORE: begin
               ptr_r <= ptr_step;
               fsm_r <= ST_FETCH;
            end
            ST_FETCH: begin
               dr_r  <= ram_rd;
               fsm_r <= ST_IDLE;
            end
            default: begin
               fsm_r <= ST_IDLE;
            end
         endcase
      end
   end

   // The RAMs carry no reset: their content is undefined until software fills it.
   always_ff @(posedge mclk_i) begin
      if (fsm_r == ST_STORE && glyph_sel_r) begin
         glyph_ram[ptr_r[5:0]] <= dr_r;
      end
      if (fsm_r == ST_STORE && !glyph_sel_r && disp_ok) begin
         display_ram[disp_idx] <= dr_r;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Read path toward the host. The command register has no read path here; it is read over APB only.

   logic [7:0] dout_r;

   wire [7:0] busy_word = {busy, ptr_r};
   wire [7:0] rd_src    = rs_s ? dr_r : busy_word;
   wire [7:0] rd_lane   = bus_width_r ? rd_src
                                      : {(nib_wait_lo_r ? rd_src[3:0] : rd_src[7:4]), 4'h0};
   wire       par_rd_oe = (mode == MODE_PAR) & e_s & rw_s;
   wire [7:0] lane_mask = bus_width_r ? 8'hFF : 8'hF0;

   always_ff @(posedge mclk_i) begin
      if (sys_rst_i || mode != MODE_PAR) begin
         dout_r <= 8'h00;
      end else begin
         dout_r <= rd_lane;
      end
   end

   assign host_data_lines_o    = dout_r;
   assign host_data_lines_oe_o = par_rd_oe ? lane_mask : {1'b0, ack_r & iic_sel, 6'h00};

   ////////////////////////////////////////////////////////////////////////////////
   // APB slave: zero wait states, read data captured in the setup cycle.

   logic [31:0] prdata_r;

   wire        hit_status = (paddr_i == `APB_STATUS_OFS);
   wire        hit_cmd    = (paddr_i == `APB_LASTCMD_OFS);
   wire        hit_busy   = (paddr_i == `APB_BUSYTIME_OFS);
   wire        apb_hit    = hit_status | hit_cmd | hit_busy;
   wire        apb_setup  = psel_i & ~penable_i;
   wire        apb_wr     = psel_i & penable_i & pwrite_i & hit_busy;
   wire [31:0] status_w   = {20'h00000, mode, bus_width_r, glyph_sel_r, busy, ptr_r};
   wire [31:0] rd_mux     = hit_status ? status_w
                          : hit_cmd    ? {24'h000000, cmd_r}
                          : hit_busy   ? {16'h0000, busy_time_r} : 32'h00000000;

   always_ff @(posedge mclk_i) begin
      if (sys_rst_i) begin
         prdata_r    <= 32'h00000000;
         busy_time_r <= 16'(BUSY_CYCLES);
      end else begin
         if (apb_setup) begin
            prdata_r <= rd_mux;
         end
         if (apb_wr) begin
            busy_time_r <= (pwdata_i[15:0] == 16'h0000) ? 16'h0001 : pwdata_i[15:0];
         end
      end
   end

   assign prdata_o  = prdata_r;
   assign pready_o  = 1'b1;
   assign pslverr_o = psel_i & penable_i & ~apb_hit;

endmodule

// File: char_display_cfg.svh
// Constants of the character display host interface: offsets, fields, resets and timing.
`ifndef CHAR_DISPLAY_CFG_SVH
`define CHAR_DISPLAY_CFG_SVH

`define APB_STATUS_OFS   8'h00
`define APB_LASTCMD_OFS  8'h04
`define APB_BUSYTIME_OFS 8'h08

`define ST_PTR_LSB   0
`define ST_BUSY_BIT  7
`define ST_GLYPH_BIT 8
`define ST_WIDTH_BIT 9
`define ST_MODE_LSB  10

`define CMD_BIT_WIDTH 4
`define CMD_BIT_INC   1

`define RST_BUS_WIDTH 1'b1
`define RST_INC       1'b1
`define RST_IIC_HI    5'h0F

`define DISP_DEPTH  80
`define GLYPH_DEPTH 64

`define BUSY_TIME_NS 37000
`define CLK_MHZ      250

`endif

// File: char_display_pkg.sv
// Types of the character display host interface.
package char_display_pkg;

   typedef enum logic [1:0] {
      MODE_PAR = 2'b00,
      MODE_IIC = 2'b01,
      MODE_SPI = 2'b10
   } link_mode_e;

   typedef enum logic [1:0] {
      ST_IDLE  = 2'b00,
      ST_STORE = 2'b01,
      ST_FETCH = 2'b11
   } ram_fsm_e;

   typedef enum logic [1:0] {
      PH_ADDR = 2'b00,
      PH_CTRL = 2'b01,
      PH_DATA = 2'b11,
      PH_SKIP = 2'b10
   } iic_phase_e;

endpackage

// File: host_port_checker_sva.sv
// Concurrent checks on the ports of the character display host interface.
module host_port_checker (
   input wire logic        mclk_i,
   input wire logic        sys_rst_i,
   input wire logic        interface_strap_hi_i,
   input wire logic        interface_strap_lo_i,
   input wire logic        enable_strobe_i,
   input wire logic        read_not_write_i,
   input wire logic        psel_i,
   input wire logic        penable_i,
   input wire logic [7:0]  host_data_lines_o,
   input wire logic [7:0]  host_data_lines_oe_o,
   input wire logic [31:0] prdata_o,
   input wire logic        pready_o,
   input wire logic        pslverr_o
);
   logic par_w;
   logic [7:0] oe_w;
   assign par_w = !interface_strap_hi_i && !interface_strap_lo_i;
   assign oe_w = host_data_lines_oe_o;
   default clocking @(posedge mclk_i); endclocking
   default disable iff (sys_rst_i);
   ////////////////////////////////////////////////////////////////////////////////
   ready_high_a: assert property (pready_o) else $error("pready low");
   err_phase_a: assert property (pslverr_o |-> psel_i && penable_i) else $error("error outside access");
   err_zero_a: assert property (pslverr_o |-> prdata_o == 32'h0) else $error("error with data");
   rdata_hold_a: assert property (!$past(psel_i && !penable_i) |-> $stable(prdata_o)) else $error("read data moved");
   oe_legal_a: assert property (oe_w inside {8'h00, 8'hFF, 8'hF0, 8'h40}) else $error("odd enables");
   par_read_a: assert property ((enable_strobe_i && read_not_write_i && par_w)[*4] |-> oe_w inside {8'hFF, 8'hF0})
      else $error("read not driven");
   par_quiet_a: assert property ((!enable_strobe_i && par_w)[*3] |-> oe_w == 8'h00) else $error("drive without strobe");
   write_quiet_a: assert property ((par_w && !read_not_write_i)[*4] |-> oe_w == 8'h00) else $error("drive on write");
   ser_quiet_a: assert property ((interface_strap_hi_i && !interface_strap_lo_i)[*4] |-> oe_w == 8'h00 && host_data_lines_o == 8'h00)
      else $error("serial drive");
   iic_ack_a: assert property ((interface_strap_lo_i)[*4] |-> oe_w inside {8'h00, 8'h40}) else $error("iic drive");
   cover property (par_w && oe_w == 8'hF0);
   cover property (par_w && oe_w == 8'hFF);
   cover property (psel_i && penable_i && pslverr_o);
   cover property (oe_w == 8'h40);
endmodule
bind char_display_host_interface host_port_checker chk (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i),
   .interface_strap_hi_i(interface_strap_hi_i), .interface_strap_lo_i(interface_strap_lo_i),
   .enable_strobe_i(enable_strobe_i), .read_not_write_i(read_not_write_i), .psel_i(psel_i), .penable_i(penable_i),
   .host_data_lines_o(host_data_lines_o), .host_data_lines_oe_o(host_data_lines_oe_o), .prdata_o(prdata_o),
   .pready_o(pready_o), .pslverr_o(pslverr_o));

// File: host_mpu.sv
// Microprocessor model driving the parallel bus, the three-line serial link and the IIC link.
module host_mpu (
   input  wire logic       mclk_i,
   input  wire logic [7:0] dev_data_i,
   input  wire logic [7:0] dev_oe_i,
   output logic            strobe_o,
   output logic            rs_o,
   output logic            rw_o,
   output logic      [7:0] lines_o
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] drv_en_r  = 8'h00;
   logic [7:0] drv_val_r = 8'h00;
   logic [7:0] lvl_r     = 8'h00;
   initial begin
      strobe_o = 1'b0;
      rs_o = 1'b0;
      rw_o = 1'b0;
   end
   // A line nobody drives flips every cycle, so a floating bit never passes for data.
   assign lines_o = (dev_oe_i & dev_data_i) | (~dev_oe_i & drv_en_r & drv_val_r) | (~dev_oe_i & ~drv_en_r & ~lvl_r);
   always @(posedge mclk_i) lvl_r <= lines_o;
   ////////////////////////////////////////////////////////////////////////////////
   task automatic strobe(input logic rs, input logic rw, input logic [7:0] d, input logic [7:0] m, output logic [7:0] q);
      @(posedge mclk_i);
      rs_o <= rs;
      rw_o <= rw;
      drv_val_r <= d;
      drv_en_r <= rw ? 8'h00 : m;
      strobe_o <= 1'b1;
      repeat (12) @(posedge mclk_i);
      q = lines_o;
      strobe_o <= 1'b0;
      repeat (4) @(posedge mclk_i);
      drv_en_r <= 8'h00;
      repeat (44) @(posedge mclk_i);
   endtask
   task automatic access(input logic rs, input logic rw, input logic [7:0] d, input logic four, output logic [7:0] q);
      logic [7:0] h;
      if (four) begin
         strobe(rs, rw, {d[7:4], 4'h0}, 8'hF0, h);
         strobe(rs, rw, {d[3:0], 4'h0}, 8'hF0, q);
         q = {h[7:4], q[7:4]};
      end else begin
         strobe(rs, rw, d, 8'hFF, q);
      end
   endtask
   task automatic ser_idle();
      @(posedge mclk_i);
      drv_val_r <= 8'h20;
      drv_en_r <= 8'hE0;
   endtask
   task automatic ser_frame(input logic [8:0] bits);
      for (int i = 8; i >= 0; i--) begin
         @(posedge mclk_i);
         drv_val_r <= {bits[i], 7'h00};
         repeat (8) @(posedge mclk_i);
         drv_val_r <= {bits[i], 7'h40};
         repeat (7) @(posedge mclk_i);
      end
      @(posedge mclk_i);
      drv_val_r <= 8'h20;
   endtask
   // A released open-drain line is driven high here, standing in for its pull-up; the device's enable wins.
   task automatic iic_frame(input logic [1:0] sa, input logic [7:0] ad, input logic [7:0] ctl, input logic [7:0] dat,
                            output logic [2:0] ack);
      logic [26:0] bits;
      bits = {ad, 1'b1, ctl, 1'b1, dat, 1'b1};
      @(posedge mclk_i);
      drv_en_r <= 8'hE3;
      drv_val_r <= {3'b111, 3'h0, sa};
      repeat (8) @(posedge mclk_i);
      drv_val_r <= {3'b110, 3'h0, sa};
      repeat (8) @(posedge mclk_i);
      drv_val_r <= {3'b100, 3'h0, sa};
      repeat (8) @(posedge mclk_i);
      for (int i = 26; i >= 0; i--) begin
         drv_val_r <= {1'b0, bits[i], 4'h0, sa};
         repeat (8) @(posedge mclk_i);
         drv_val_r <= {1'b1, bits[i], 4'h0, sa};
         repeat (6) @(posedge mclk_i);
         if (i % 9 == 0) ack[i / 9] = lines_o[6];
         repeat (2) @(posedge mclk_i);
      end
      drv_val_r <= {3'b000, 3'h0, sa};
      repeat (8) @(posedge mclk_i);
      drv_val_r <= {3'b100, 3'h0, sa};
      repeat (8) @(posedge mclk_i);
      drv_val_r <= {3'b110, 3'h0, sa};
      repeat (8) @(posedge mclk_i);
      drv_val_r <= {3'b111, 3'h0, sa};
   endtask
endmodule

// File: tb.sv
// Self-checking bench for the character display host interface.
`include "char_display_cfg.svh"
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic        mclk_i = 1'b0;
   logic        sys_rst_i = 1'b1;
   logic        strap_hi = 1'b0;
   logic        strap_lo = 1'b0;
   logic        psel = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite = 1'b0;
   logic [7:0]  paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   wire logic   strobe, rs, rw, pready, pslverr;
   wire logic [7:0]  lines, dout, oe;
   wire logic [31:0] prdata;
   int          miscompares = 0;
   int          total_checks = 0;
   int          depth;
   logic [31:0] r;
   logic        e;
   logic [7:0]  q, a, s, base, b;
   logic [2:0]  ak;
   logic [7:0]  d [3];
   always #2 mclk_i = ~mclk_i;
   char_display_host_interface #(.BUSY_CYCLES(20)) uut (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i),
      .interface_strap_hi_i(strap_hi), .interface_strap_lo_i(strap_lo), .enable_strobe_i(strobe),
      .register_select_i(rs), .read_not_write_i(rw), .host_data_lines_i(lines), .host_data_lines_o(dout),
      .host_data_lines_oe_o(oe), .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr),
      .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr));
   host_mpu host (.mclk_i(mclk_i), .dev_data_i(dout), .dev_oe_i(oe), .strobe_o(strobe), .rs_o(rs), .rw_o(rw),
      .lines_o(lines));
   ////////////////////////////////////////////////////////////////////////////////
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         miscompares++;
         $display("CHECK FAILED at %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic apb(input logic w, input logic [7:0] ad, input logic [31:0] wd);
      @(posedge mclk_i);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= ad;
      pwdata <= wd;
      @(posedge mclk_i);
      penable <= 1'b1;
      @(posedge mclk_i);
      while (pready !== 1'b1) @(posedge mclk_i);
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wait_idle(input logic four);
      for (int i = 0; i < 20; i++) begin
         host.access(1'b0, 1'b1, 8'h00, four, q);
         if (q[7] === 1'b0) break;
      end
   endtask
   task automatic instr(input logic [7:0] c, input logic four);
      host.access(1'b0, 1'b0, c, four, q);
      wait_idle(four);
   endtask
   // Pointer after n steps from p in a RAM of dep entries; n may be negative.
   function automatic int ptr_after(input int p, input int n, input int dep);
      return (p + n + dep) % dep;
   endfunction
   task automatic report_and_stop();
      $display("checks %0d miscompares %0d", total_checks, miscompares);
      if (miscompares == 0 && total_checks > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (40000) @(posedge mclk_i);
      miscompares++;
      report_and_stop();
   end
   initial begin
      void'($urandom(20882));
      repeat (5) @(posedge mclk_i);
      sys_rst_i <= 1'b0;
      repeat (4) @(posedge mclk_i);
      apb(1'b0, 8'h00, 32'h0); chk(r, 32'h200);
      apb(1'b0, 8'h08, 32'h0); chk(r, 32'd20);
      apb(1'b1, 8'h0C, 32'h5); chk({r[30:0], e}, 32'h1);
      apb(1'b1, 8'h08, 32'd200);
      a = 8'($urandom_range(0, 79));
      host.access(1'b0, 1'b0, 8'h80 | a, 1'b0, q);
      host.access(1'b0, 1'b1, 8'h00, 1'b0, q); chk(q[7], 1'b1);
      host.access(1'b0, 1'b0, 8'h80 | (8'd79 - a), 1'b0, q);
      wait_idle(1'b0); chk(q, a);
      apb(1'b1, 8'h08, 32'd20);
      for (int k = 0; k < 3; k++) begin
         if (k == 1) begin
            // The width changes with this byte, so the busy poll already runs in 4-bit form.
            host.access(1'b0, 1'b0, 8'h20, 1'b0, q);
            wait_idle(1'b1);
            apb(1'b0, 8'h00, 32'h0); chk(r[9], 1'b0);
         end
         s = (k == 0) ? 8'd78 : (k == 1) ? 8'($urandom_range(0, 79)) : 8'd62;
         base = (k == 2) ? 8'h40 : 8'h80;
         depth = (k == 2) ? 64 : 80;
         instr(base | s, k > 0);
         foreach (d[j]) begin
            d[j] = 8'($urandom);
            host.access(1'b1, 1'b0, d[j], k > 0, q);
         end
         host.access(1'b0, 1'b1, 8'h00, k > 0, q); chk(q[6:0], ptr_after(s, 3, depth));
         instr(base | s, k > 0);
         foreach (d[j]) begin
            host.access(1'b1, 1'b1, 8'h00, k > 0, q); chk(q, d[j]);
         end
      end
      instr(8'h04, 1'b1);
      instr(8'h80, 1'b1);
      host.access(1'b1, 1'b0, 8'h5A, 1'b1, q);
      host.access(1'b0, 1'b1, 8'h00, 1'b1, q); chk(q[6:0], ptr_after(0, -1, 80));
      instr(8'h06, 1'b1);
      apb(1'b0, 8'h04, 32'h0); chk(r, 32'h06);
      instr(8'h30, 1'b1);
      apb(1'b0, 8'h00, 32'h0); chk(r[9], 1'b1);
      host.ser_idle();
      strap_hi <= 1'b1;
      repeat (8) @(posedge mclk_i);
      apb(1'b0, 8'h00, 32'h0); chk(r[11:10], 2'b10);
      s = 8'($urandom_range(0, 78));
      a = 8'($urandom);
      host.ser_frame({1'b0, 8'h80 | s});
      repeat (40) @(posedge mclk_i);
      host.ser_frame({1'b1, a});
      repeat (40) @(posedge mclk_i);
      apb(1'b0, 8'h00, 32'h0); chk(r[6:0], ptr_after(s, 1, 80));
      strap_hi <= 1'b0;
      strap_lo <= 1'b1;
      repeat (8) @(posedge mclk_i);
      apb(1'b0, 8'h00, 32'h0); chk(r[11:10], 2'b01);
      b = 8'($urandom);
      host.iic_frame(2'b10, {`RST_IIC_HI, 2'b10, 1'b0}, 8'h00, 8'h81 + s, ak); chk(ak, 3'b000);
      host.iic_frame(2'b10, {`RST_IIC_HI, 2'b10, 1'b0}, 8'h40, b, ak); chk(ak, 3'b000);
      host.iic_frame(2'b10, {`RST_IIC_HI, 2'b01, 1'b0}, 8'h40, 8'h00, ak); chk(ak, 3'b111);
      apb(1'b0, 8'h00, 32'h0); chk(r[6:0], ptr_after(s, 2, 80));
      strap_lo <= 1'b0;
      repeat (8) @(posedge mclk_i);
      instr(8'h80 | s, 1'b0);
      host.access(1'b1, 1'b1, 8'h00, 1'b0, q); chk(q, a);
      host.access(1'b1, 1'b1, 8'h00, 1'b0, q); chk(q, b);
      report_and_stop();
   end
endmodule
